// [pbs_ctrl.sv]
`include "pbs_consts.svh"

module pbs_ctrl #(
    parameter int MULT_W = 6,
    parameter int DIV_W = 3
) (
    // Clock and reset
    input wire logic MCLK_I,
    input wire logic RST_B_I,
    // Crystal and oscillator feedback events
    input wire logic XTAL_TICK_I,
    input wire logic VCO_TICK_I,
    // Mode control bits
    input wire logic [MULT_W-1:0] MULT_I,
    input wire logic [DIV_W-1:0] REFDIV_I,
    input wire logic AUTO_I,
    input wire logic ACQ_I,
    // Clock and loop outputs
    output logic REF_TICK_O,
    output logic BUS_TICK_O,
    output logic HIGH_GAIN_O,
    output pbs_pkg::pbs_state_e TRACK_O,
    output logic LOCK_O,
    output logic CFG_ERR_O
);
    import pbs_pkg::*;

    // True when err is at most thr/1024 of the expected count
    function automatic logic err_ok(input pbs_count_t err,
                                    input pbs_count_t expct,
                                    input logic [6:0] thr);
        logic [23:0] lhs;
        logic [23:0] rhs;
        lhs = {11'h000, err} << `PBS_ERR_SHIFT;
        rhs = {11'h000, expct} * {17'h00000, thr};
        return lhs <= rhs;
    endfunction

    logic ref_tick;
    pbs_ref_div #(.DIV_W(DIV_W)) u_ref_div (
        .clk_i(MCLK_I),
        .rst_b_i(RST_B_I),
        .xtal_tick_i(XTAL_TICK_I),
        .div_i(REFDIV_I),
        .ref_tick_o(ref_tick)
    );
    assign REF_TICK_O = ref_tick;

    // Bus tick synthesis
    logic [7:0] acc;
    logic [7:0] next_acc;
    logic next_bus_tick;
    logic next_cfg_err;
    logic [8:0] sum;
    logic [8:0] step;
    logic [8:0] divp1;
    logic [8:0] diff;

    always_comb begin
        step = XTAL_TICK_I ? 9'({1'b0, MULT_I} + 1'b1) : 9'h000;
        divp1 = 9'({1'b0, REFDIV_I} + 1'b1);
        sum = 9'({1'b0, acc} + step);
        diff = sum - divp1;
        next_bus_tick = 1'b0;
        next_acc = sum[8] ? 8'hff : sum[7:0];
        if (sum >= divp1) begin
            next_bus_tick = 1'b1;
            // Saturate instead of wrapping if crystal ticks come too fast
            next_acc = diff[8] ? 8'hff : diff[7:0];
        end
        next_cfg_err = ({3'h0, MULT_I} < {6'h00, REFDIV_I});
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            acc <= `PBS_ACC_RST;
            BUS_TICK_O <= 1'b0;
            CFG_ERR_O <= 1'b0;
        end else begin
            acc <= next_acc;
            BUS_TICK_O <= next_bus_tick;
            CFG_ERR_O <= next_cfg_err;
        end
    end

    // Frequency measurement over a window of reference periods
    pbs_count_t vco_cnt;
    pbs_count_t next_vco_cnt;
    logic [`PBS_WIN_LOG2-1:0] win_cnt;
    logic [`PBS_WIN_LOG2-1:0] next_win_cnt;
    logic eval;
    pbs_count_t meas;
    pbs_count_t expct;
    pbs_count_t err;

    always_comb begin
        eval = ref_tick && (win_cnt == `PBS_WIN_LOG2'(`PBS_WIN_LEN - 1));
        meas = vco_cnt + 13'(VCO_TICK_I);
        expct = pbs_count_t'({7'h00, MULT_I} + 1'b1) << `PBS_WIN_LOG2;
        err = (meas > expct) ? meas - expct : expct - meas;
        next_win_cnt = ref_tick ? win_cnt + 1'b1 : win_cnt;
        if (eval) begin
            next_vco_cnt = `PBS_CNT_RST;
        end else if (VCO_TICK_I && vco_cnt != 13'h1fff) begin
            next_vco_cnt = vco_cnt + 1'b1;
        end else begin
            next_vco_cnt = vco_cnt;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            vco_cnt <= `PBS_CNT_RST;
            win_cnt <= '0;
        end else begin
            vco_cnt <= next_vco_cnt;
            win_cnt <= next_win_cnt;
        end
    end

    // Bandwidth mode and lock detector
    pbs_state_e state;
    pbs_state_e next_state;
    logic next_lock;
    logic trk_in_ok;
    logic trk_out_bad;
    logic lock_ok;
    logic unlock_bad;

    always_comb begin
        trk_in_ok = err_ok(err, expct, `PBS_TRK_IN_THR);
        trk_out_bad = !err_ok(err, expct, `PBS_TRK_OUT_THR);
        lock_ok = err_ok(err, expct, `PBS_LOCK_THR);
        unlock_bad = !err_ok(err, expct, `PBS_UNLOCK_THR);
        next_state = state;
        if (!AUTO_I) begin
            next_state = ACQ_I ? PBS_TRK : PBS_ACQ;
        end else if (eval) begin
            case (state)
                PBS_ACQ: begin
                    if (trk_in_ok) begin
                        next_state = PBS_TRK;
                    end
                end
                PBS_TRK: begin
                    if (trk_out_bad) begin
                        next_state = PBS_ACQ;
                    end
                end
                default: begin
                    next_state = PBS_ACQ;
                end
            endcase
        end
        next_lock = LOCK_O;
        if (eval && lock_ok) begin
            next_lock = 1'b1;
        end else if (eval && unlock_bad) begin
            next_lock = 1'b0;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            state <= PBS_ACQ;
            LOCK_O <= 1'b0;
        end else begin
            state <= next_state;
            LOCK_O <= next_lock;
        end
    end

    assign TRACK_O = state;
    assign HIGH_GAIN_O = (state == PBS_ACQ);

    // Checks
    property p_bus_unit;
        @(posedge MCLK_I) disable iff (!RST_B_I)
        (XTAL_TICK_I && REFDIV_I == '0) |=> BUS_TICK_O;
    endproperty
    a_bus_unit: assert property (p_bus_unit)
        else $error("Bus tick missing for divide by one");

    property p_auto_acq_to_trk;
        @(posedge MCLK_I) disable iff (!RST_B_I)
        (AUTO_I && state == PBS_ACQ && eval && trk_in_ok)
        |=> (TRACK_O == PBS_TRK && !HIGH_GAIN_O);
    endproperty
    a_auto_acq_to_trk: assert property (p_auto_acq_to_trk)
        else $error("Auto mode did not enter tracking");

    property p_forced_acq;
        @(posedge MCLK_I) disable iff (!RST_B_I)
        (!AUTO_I && !ACQ_I) [*2] |-> HIGH_GAIN_O;
    endproperty
    a_forced_acq: assert property (p_forced_acq)
        else $error("Forced acquisition lost high gain");

    property p_lock_any_mode;
        @(posedge MCLK_I) disable iff (!RST_B_I)
        (eval && lock_ok) |=> LOCK_O;
    endproperty
    a_lock_any_mode: assert property (p_lock_any_mode)
        else $error("Lock not reported after close match");

    property p_unlock;
        @(posedge MCLK_I) disable iff (!RST_B_I)
        (eval && unlock_bad) |=> !LOCK_O;
    endproperty
    a_unlock: assert property (p_unlock)
        else $error("Lock held after large error");

    property p_trk_exit;
        @(posedge MCLK_I) disable iff (!RST_B_I)
        (AUTO_I && state == PBS_TRK && eval && trk_out_bad)
        |=> HIGH_GAIN_O;
    endproperty
    a_trk_exit: assert property (p_trk_exit)
        else $error("Tracking kept despite large error");

    property p_trk_hold;
        @(posedge MCLK_I) disable iff (!RST_B_I)
        (AUTO_I && state == PBS_TRK && !eval) |=> TRACK_O == PBS_TRK;
    endproperty
    a_trk_hold: assert property (p_trk_hold)
        else $error("Tracking left between evaluations");

    c_enter_trk: cover property (@(posedge MCLK_I) disable iff (!RST_B_I)
        AUTO_I && state == PBS_ACQ ##1 state == PBS_TRK);
    c_lock: cover property (@(posedge MCLK_I) disable iff (!RST_B_I)
        !LOCK_O ##1 LOCK_O);
    c_manual_lock: cover property (@(posedge MCLK_I) disable iff (!RST_B_I)
        !AUTO_I && !ACQ_I && !LOCK_O ##1 LOCK_O);
endmodule

// [pbs_consts.svh]
`ifndef PBS_CONSTS_SVH
`define PBS_CONSTS_SVH

// Measurement window, in reference periods (power of two)
`define PBS_WIN_LOG2 6
`define PBS_WIN_LEN 64
// Error thresholds in units of 1/1024 of the expected count
`define PBS_ERR_SHIFT 10
`define PBS_TRK_IN_THR 7'h28
`define PBS_TRK_OUT_THR 7'h48
`define PBS_LOCK_THR 7'h0f
`define PBS_UNLOCK_THR 7'h19
// Reset values
`define PBS_ACC_RST 8'h00
`define PBS_CNT_RST 13'h0000

`endif

// [pbs_pkg.sv]
package pbs_pkg;
    typedef enum logic [0:0] {
        PBS_ACQ = 1'b0,
        PBS_TRK = 1'b1
    } pbs_state_e;
    typedef logic [12:0] pbs_count_t;
endpackage

// [pbs_ref_div.sv]
`include "pbs_consts.svh"

module pbs_ref_div #(
    parameter int DIV_W = 3
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic xtal_tick_i,
    input wire logic [DIV_W-1:0] div_i,
    output logic ref_tick_o
);
    logic [DIV_W-1:0] cnt;
    logic [DIV_W-1:0] next_cnt;
    logic next_ref_tick;

    // One reference tick per (div_i + 1) crystal ticks
    always_comb begin
        next_cnt = cnt;
        next_ref_tick = 1'b0;
        if (xtal_tick_i) begin
            if (cnt >= div_i) begin
                next_cnt = '0;
                next_ref_tick = 1'b1;
            end else begin
                next_cnt = cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            cnt <= '0;
            ref_tick_o <= 1'b0;
        end else begin
            cnt <= next_cnt;
            ref_tick_o <= next_ref_tick;
        end
    end

    property p_ref_from_xtal;
        @(posedge clk_i) disable iff (!rst_b_i)
        ref_tick_o |-> $past(xtal_tick_i);
    endproperty
    a_ref_from_xtal: assert property (p_ref_from_xtal)
        else $error("Reference tick without a crystal tick");

    property p_div_zero_passes;
        @(posedge clk_i) disable iff (!rst_b_i)
        (xtal_tick_i && div_i == '0) |=> ref_tick_o;
    endproperty
    a_div_zero_passes: assert property (p_div_zero_passes)
        else $error("Divide by one missed a crystal tick");
endmodule

// [test_pbs_ctrl.sv]
module test_pbs_ctrl;
    timeunit 1ns;
    timeprecision 100ps;
    import pbs_pkg::*;

    typedef struct {
        logic [5:0] m;
        logic [2:0] r;
        logic [15:0] nref;
        logic [15:0] nbus;
        logic cerr;
    } pbs_row_s;

    logic MCLK_I = 1'b0;
    logic RST_B_I = 1'b0;
    logic XTAL_TICK_I = 1'b0;
    logic VCO_TICK_I = 1'b0;
    logic AUTO_I = 1'b0;
    logic ACQ_I = 1'b0;
    logic [5:0] MULT_I = 6'h00;
    logic [2:0] REFDIV_I = 3'h0;
    logic REF_TICK_O;
    logic BUS_TICK_O;
    logic HIGH_GAIN_O;
    logic LOCK_O;
    logic CFG_ERR_O;
    pbs_state_e TRACK_O;
    int err_total = 0;
    int n_checks = 0;
    int vper = 0;
    int vcnt = 0;
    logic [15:0] n_ref = 16'h0000;
    logic [15:0] n_bus = 16'h0000;
    // Multiplier, divider, ref ticks and bus ticks for 8 crystal ticks
    pbs_row_s rows [5] = '{
        '{6'h01, 3'h0, 16'h0008, 16'h0010, 1'b0},
        '{6'h3f, 3'h0, 16'h0008, 16'h0200, 1'b0},
        '{6'h00, 3'h3, 16'h0002, 16'h0002, 1'b1},
        '{6'h0c, 3'h7, 16'h0001, 16'h000d, 1'b0},
        '{6'h05, 3'h1, 16'h0004, 16'h0018, 1'b0}
    };

    pbs_ctrl #(.MULT_W(6), .DIV_W(3)) uut (
        .MCLK_I(MCLK_I), .RST_B_I(RST_B_I),
        .XTAL_TICK_I(XTAL_TICK_I), .VCO_TICK_I(VCO_TICK_I),
        .MULT_I(MULT_I), .REFDIV_I(REFDIV_I),
        .AUTO_I(AUTO_I), .ACQ_I(ACQ_I),
        .REF_TICK_O(REF_TICK_O), .BUS_TICK_O(BUS_TICK_O),
        .HIGH_GAIN_O(HIGH_GAIN_O), .TRACK_O(TRACK_O),
        .LOCK_O(LOCK_O), .CFG_ERR_O(CFG_ERR_O)
    );

    always #12.5 MCLK_I = ~MCLK_I;

    // Oscillator feedback: one pulse every vper cycles, off when zero
    always @(posedge MCLK_I) begin
        #2;
        if (vper != 0) begin
            vcnt = (vcnt + 1 >= vper) ? 0 : vcnt + 1;
        end
        VCO_TICK_I = (vper != 0 && vcnt == 0);
    end

    // Tick counters sample mid-cycle, clear while reset is held
    always @(negedge MCLK_I) begin
        if (!RST_B_I) begin
            n_ref <= 16'h0000;
            n_bus <= 16'h0000;
        end else begin
            if (REF_TICK_O === 1'b1) n_ref <= n_ref + 16'h0001;
            if (BUS_TICK_O === 1'b1) n_bus <= n_bus + 16'h0001;
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s got %0h expected %0h",
                     $time, what, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge MCLK_I);
        #2;
    endtask

    task automatic chk_mode(input pbs_state_e st, input logic hg,
                            input logic lk);
        chk(16'(TRACK_O), 16'(st), "loop state");
        chk({15'h0000, HIGH_GAIN_O}, {15'h0000, hg}, "high gain");
        chk({15'h0000, LOCK_O}, {15'h0000, lk}, "lock");
    endtask

    task automatic do_reset;
        RST_B_I = 1'b0;
        cyc(5);
        chk_mode(PBS_ACQ, 1'b1, 1'b0);
        RST_B_I = 1'b1;
    endtask

    // Crystal ticks spaced 64 cycles apart, slow enough for exact ratios
    task automatic xticks(input int n);
        repeat (n) begin
            XTAL_TICK_I = 1'b1;
            cyc(1);
            XTAL_TICK_I = 1'b0;
            cyc(63);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        #2500us;
        err_total++;
        $display("mismatch at %0t: watchdog expired", $time);
        report_and_stop();
    end

    initial begin
        foreach (rows[i]) begin
            MULT_I = rows[i].m;
            REFDIV_I = rows[i].r;
            do_reset();
            cyc(2);
            chk(16'(CFG_ERR_O), 16'(rows[i].cerr), "cfg");
            xticks(8);
            cyc(10);
            chk(n_ref, rows[i].nref, "ref ticks");
            chk(n_bus, rows[i].nbus, "bus ticks");
        end
        // Automatic mode: three measurement windows per step
        MULT_I = 6'h01;
        REFDIV_I = 3'h0;
        AUTO_I = 1'b1;
        do_reset();
        vper = 32;
        xticks(192);
        chk_mode(PBS_TRK, 1'b0, 1'b1);
        // About 6.5% error sits inside the hysteresis band
        vper = 30;
        xticks(192);
        chk_mode(PBS_TRK, 1'b0, 1'b0);
        vper = 27;
        xticks(192);
        chk_mode(PBS_ACQ, 1'b1, 1'b0);
        vper = 30;
        xticks(192);
        chk_mode(PBS_ACQ, 1'b1, 1'b0);
        // Manual forced acquisition still reports lock
        AUTO_I = 1'b0;
        vper = 32;
        xticks(192);
        chk_mode(PBS_ACQ, 1'b1, 1'b1);
        ACQ_I = 1'b1;
        cyc(2);
        chk_mode(PBS_TRK, 1'b0, 1'b1);
        report_and_stop();
    end
endmodule
